// ### tmwd_pkg.sv
`default_nettype none

package tmwd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] OFS_WATCHDOG_CONTROL = 8'h04;
    localparam logic [7:0] OFS_INTERRUPT_MASK = 8'h08;
    localparam logic [7:0] OFS_TIMEBASE = 8'h0C;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h10;
    localparam logic [7:0] OFS_COMMAND = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'hBF;
    localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h80;
    localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;
    localparam logic [4:0] IMASK_UNUSED_ONES = 5'h1F;
    localparam logic [7:0] TIMEBASE_RESET = 8'h00;
    localparam logic [7:0] TIMEBASE_MAX = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int TC_SCRATCH = 7;
    localparam int TC_GIE = 6;
    localparam int TC_SOURCE = 5;
    localparam int TC_EDGE = 4;
    localparam int TC_PAB = 3;
    localparam int TC_RATIO_MSB = 2;
    localparam int WC_ENABLE = 7;
    localparam int WC_EXT_SELECT = 6;
    localparam int IRQ_EXT = 2;
    localparam int IRQ_CHANGE = 1;
    localparam int IRQ_OVF = 0;
    localparam int CMD_DISABLE = 0;
    localparam int CMD_ENABLE = 1;
    localparam int CMD_RETURN = 2;
    localparam int CMD_WDT_CLEAR = 3;
    localparam int CMD_SLEEP = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam logic [1:0] DIV2_LAST = 2'h1;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam int HCLK_MHZ = 125;
    localparam int WDT_TIMEOUT_MS = 18;
    localparam int WDT_TIMEOUT_CYC = WDT_TIMEOUT_MS * 1000 * HCLK_MHZ;
    localparam int WDT_CNT_W = 22;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b01,
        MODE_SLEEP = 2'b10
    } tmwd_mode_type;

    // Low k bits set; k of 8 gives all ones
    function automatic logic [7:0] tmwd_tap_mask(input logic [3:0] k);
        logic [8:0] m;
        m = (9'h001 << k) - 9'h001;
        return m[7:0];
    endfunction : tmwd_tap_mask

endpackage : tmwd_pkg

`default_nettype wire

// ### tmwd_prescaler.sv
`default_nettype none

module tmwd_prescaler (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic inc,
    input wire logic clr,
    input wire logic [3:0] tap,
    output logic pulse,
    output logic [7:0] value
);

    logic [7:0] cnt_q;
    logic [7:0] mask;

    ////////////////////////////////////////////////////////////////////////////
    // Ripple-free divider: one pulse each 2^tap increments
    assign mask = tmwd_pkg::tmwd_tap_mask(tap);
    assign pulse = inc & ~clr & ((cnt_q & mask) == mask);
    assign value = cnt_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 8'h00;
        end else if (clr) begin
            cnt_q <= 8'h00;
        end else if (inc) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

endmodule : tmwd_prescaler

`default_nettype wire

// ### tmwd_top.sv
// Functional notes
// - Global enable clears on disable or interrupt entry, sets on enable or return.
// - Source bit 0 counts instruction cycles; 1 counts external counter pin edges.
// - External mode counts rising edges with polarity 0, falling with polarity 1.
// - Prescaler serves counter when assign bit is 0, watchdog when 1.
// - Ratio n gives counter 1:2^(n+1) and watchdog 1:2^n.
// - Timer control bit 7 is plain storage; whole register read/write.
// - Watchdog runs only while its enable bit is 1; bit read/write.
// - Select bit 1 makes pin0 the interrupt input; 0 masks its path.
// - Six low watchdog control bits are plain storage.
// - Upper five interrupt mask bits always read as 1.
// - Mask bits 2,1,0 enable external, port change and overflow interrupts.
// - Prescaler is an 8-bit counter divided by the ratio field.
// - Writing the counter clears the prescaler while assigned to the counter.
// - Watchdog clear or sleep clears watchdog, and prescaler when assigned to it.
// - Counter is 8 bits; internal unprescaled source adds one per instruction.
// - Instruction clock is main clock over 2, or over 4 with option set.
// - Watchdog runs on its own free clock and keeps counting in sleep.
// - Enabled watchdog timeout resets the device, awake or asleep.
// - Software may enable or disable the watchdog at any time.
// - Unprescaled watchdog timeout is about 18 ms.
// - Reset sets timer control to all ones except global enable.
// - Reset sets watchdog enable and clears external pin select.
// - Reset clears the three interrupt enable bits.
`default_nettype none

module tmwd_top #(
    parameter int WDT_PERIOD_CYC = tmwd_pkg::WDT_TIMEOUT_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic clk_code_option,
    input wire logic port6_pin0,
    input wire logic port6_pin2,
    input wire logic port_change_event,
    input wire logic irq_entry,
    output logic irq_request,
    output logic wdt_reset_req,
    output logic sleep_active,
    output logic port6_pin0_is_irq,
    output logic port6_pin2_is_counter,
    output logic ext_irq_pin_level
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic addr_ok;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_mux;
    logic wr_tc, wr_wc, wr_im, wr_tb, wr_fl, wr_cmd;
    logic cmd_irq_disable_instr, cmd_eni, cmd_irq_return_instr, cmd_watchdog_clear_instr, cmd_sleep;
    logic [7:0] tc_q;
    logic [7:0] wc_q;
    logic [2:0] imask_q;
    logic [7:0] tb_q;
    logic [2:0] flag_q;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    tmwd_pkg::tmwd_mode_type mode_q;
    logic [1:0] div_q;
    logic [1:0] div_last;
    logic instr_tick;
    logic pin2_q, pin0_q;
    logic ext_event;
    logic count_event;
    logic prescaler_assign;
    logic [2:0] ratio;
    logic pre_inc, pre_clr, pre_pulse;
    logic [3:0] pre_tap;
    logic [7:0] pre_value;
    logic tb_step, tb_wrap;
    logic [tmwd_pkg::WDT_CNT_W-1:0] wdt_cnt_q;
    logic [tmwd_pkg::WDT_CNT_W-1:0] wdt_last;
    logic wdt_en, wdt_clear, wdt_base_tick, wdt_step, wdt_timeout;
    logic wdt_reset_q, irq_q;
    logic wake;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states
    assign addr_ok = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_ok & hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    // Read data captured at address phase so it stands for the whole data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_ok & ~hwrite) begin
            hrdata_q <= rd_mux;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            tmwd_pkg::OFS_TIMER_CONTROL: rd_mux[7:0] = tc_q;
            tmwd_pkg::OFS_WATCHDOG_CONTROL: rd_mux[7:0] = wc_q;
            tmwd_pkg::OFS_INTERRUPT_MASK: rd_mux[7:0] = {tmwd_pkg::IMASK_UNUSED_ONES, imask_q};
            tmwd_pkg::OFS_TIMEBASE: rd_mux[7:0] = tb_q;
            tmwd_pkg::OFS_IRQ_FLAG: rd_mux[2:0] = flag_q;
            tmwd_pkg::OFS_STATUS: rd_mux[15:0] = {pre_value, 7'h00, sleep_active};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    assign wr_tc = wr_pend_q & (wr_addr_q == tmwd_pkg::OFS_TIMER_CONTROL);
    assign wr_wc = wr_pend_q & (wr_addr_q == tmwd_pkg::OFS_WATCHDOG_CONTROL);
    assign wr_im = wr_pend_q & (wr_addr_q == tmwd_pkg::OFS_INTERRUPT_MASK);
    assign wr_tb = wr_pend_q & (wr_addr_q == tmwd_pkg::OFS_TIMEBASE);
    assign wr_fl = wr_pend_q & (wr_addr_q == tmwd_pkg::OFS_IRQ_FLAG);
    assign wr_cmd = wr_pend_q & (wr_addr_q == tmwd_pkg::OFS_COMMAND);

    // Instruction strobes, one cycle each
    assign cmd_irq_disable_instr = wr_cmd & hwdata[tmwd_pkg::CMD_DISABLE];
    assign cmd_eni = wr_cmd & hwdata[tmwd_pkg::CMD_ENABLE];
    assign cmd_irq_return_instr = wr_cmd & hwdata[tmwd_pkg::CMD_RETURN];
    assign cmd_watchdog_clear_instr = wr_cmd & hwdata[tmwd_pkg::CMD_WDT_CLEAR];
    assign cmd_sleep = wr_cmd & hwdata[tmwd_pkg::CMD_SLEEP];

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tc_q <= tmwd_pkg::TIMER_CONTROL_RESET;
        end else begin
            if (wr_tc) begin
                tc_q <= hwdata[7:0];
            end
            // Instruction beats a same-cycle register write
            if (cmd_irq_disable_instr | irq_entry) begin
                tc_q[tmwd_pkg::TC_GIE] <= 1'b0;
            end else if (cmd_eni | cmd_irq_return_instr) begin
                tc_q[tmwd_pkg::TC_GIE] <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wc_q <= tmwd_pkg::WATCHDOG_CONTROL_RESET;
        end else if (wr_wc) begin
            wc_q <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            imask_q <= tmwd_pkg::IRQ_ENABLE_RESET;
        end else if (wr_im) begin
            imask_q <= hwdata[2:0];
        end
    end

    assign prescaler_assign = tc_q[tmwd_pkg::TC_PAB];
    assign ratio = tc_q[tmwd_pkg::TC_RATIO_MSB:0];
    assign wdt_en = wc_q[tmwd_pkg::WC_ENABLE];
    assign port6_pin0_is_irq = wc_q[tmwd_pkg::WC_EXT_SELECT];
    assign port6_pin2_is_counter = tc_q[tmwd_pkg::TC_SOURCE];
    assign ext_irq_pin_level = pin0_q;

    ////////////////////////////////////////////////////////////////////////////
    // Sleep mode; main oscillator stops so the instruction clock halts
    assign wake = (|(flag_q & imask_q)) | wdt_timeout;
    assign sleep_active = (mode_q == tmwd_pkg::MODE_SLEEP);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= tmwd_pkg::MODE_RUN;
        end else begin
            case (mode_q)
                tmwd_pkg::MODE_RUN: if (cmd_sleep) begin
                    mode_q <= tmwd_pkg::MODE_SLEEP;
                end
                tmwd_pkg::MODE_SLEEP: if (wake) begin
                    mode_q <= tmwd_pkg::MODE_RUN;
                end
                default: mode_q <= tmwd_pkg::MODE_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction cycle divider
    assign div_last = clk_code_option ? tmwd_pkg::DIV4_LAST : tmwd_pkg::DIV2_LAST;
    assign instr_tick = ~sleep_active & (div_q == div_last);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 2'h0;
        end else if (~sleep_active) begin
            div_q <= instr_tick ? 2'h0 : div_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter source; pins are synchronous so one delay flop suffices
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin2_q <= 1'b0;
            pin0_q <= 1'b1;
        end else begin
            pin2_q <= port6_pin2;
            pin0_q <= port6_pin0;
        end
    end

    assign ext_event = tc_q[tmwd_pkg::TC_EDGE] ? (pin2_q & ~port6_pin2)
                                               : (~pin2_q & port6_pin2);
    assign count_event = tc_q[tmwd_pkg::TC_SOURCE] ? ext_event : instr_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Shared prescaler
    assign pre_inc = prescaler_assign ? wdt_base_tick : count_event;
    assign wdt_clear = cmd_watchdog_clear_instr | cmd_sleep;
    assign pre_clr = prescaler_assign ? wdt_clear : wr_tb;
    assign pre_tap = prescaler_assign ? {1'b0, ratio} : ({1'b0, ratio} + 4'h1);
    assign tb_step = prescaler_assign ? count_event : pre_pulse;
    assign wdt_step = prescaler_assign ? pre_pulse : wdt_base_tick;

    tmwd_prescaler u_prescaler (
        .hclk(hclk),
        .hresetn(hresetn),
        .inc(pre_inc),
        .clr(pre_clr),
        .tap(pre_tap),
        .pulse(pre_pulse),
        .value(pre_value)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Timebase counter; software write wins over a count
    assign tb_wrap = tb_step & ~wr_tb & (tb_q == tmwd_pkg::TIMEBASE_MAX);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tb_q <= tmwd_pkg::TIMEBASE_RESET;
        end else if (wr_tb) begin
            tb_q <= hwdata[7:0];
        end else if (tb_step) begin
            tb_q <= tb_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog; free clock stands in for the RC oscillator, not gated by sleep
    localparam int WDT_LAST_I = WDT_PERIOD_CYC - 1;
    assign wdt_last = WDT_LAST_I[tmwd_pkg::WDT_CNT_W-1:0];
    assign wdt_base_tick = wdt_en & ~wdt_clear & (wdt_cnt_q == wdt_last);
    assign wdt_timeout = wdt_en & wdt_step;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_cnt_q <= '0;
        end else if (wdt_clear) begin
            wdt_cnt_q <= '0;
        end else if (wdt_en) begin
            wdt_cnt_q <= wdt_base_tick ? '0 : wdt_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_reset_q <= 1'b0;
        end else begin
            wdt_reset_q <= wdt_timeout;
        end
    end
    assign wdt_reset_req = wdt_reset_q;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt flags, write one to clear; a new event beats the clear
    assign flag_set[tmwd_pkg::IRQ_EXT] = port6_pin0_is_irq & pin0_q & ~port6_pin0;
    assign flag_set[tmwd_pkg::IRQ_CHANGE] = port_change_event;
    assign flag_set[tmwd_pkg::IRQ_OVF] = tb_wrap;
    assign flag_clr = wr_fl ? hwdata[2:0] : 3'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= 3'h0;
        end else begin
            flag_q <= (flag_q & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= tc_q[tmwd_pkg::TC_GIE] & (|(flag_q & imask_q));
        end
    end
    assign irq_request = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_GIE_DISABLE: assert property ((cmd_irq_disable_instr | irq_entry) |=> !tc_q[tmwd_pkg::TC_GIE])
        else $error("global enable not cleared");
    AST_GIE_ENABLE: assert property ((cmd_eni & !cmd_irq_disable_instr & !irq_entry)
        |=> tc_q[tmwd_pkg::TC_GIE])
        else $error("global enable not set");
    AST_INT_STEP: assert property ((prescaler_assign & !tc_q[tmwd_pkg::TC_SOURCE] & instr_tick & !wr_tb)
        |=> tb_q == $past(tb_q) + 8'h01)
        else $error("internal step missed");
    AST_EXT_RISE: assert property ((prescaler_assign & tc_q[tmwd_pkg::TC_SOURCE]
        & !tc_q[tmwd_pkg::TC_EDGE] & !wr_tb & $rose(port6_pin2)) |=> tb_q == $past(tb_q) + 8'h01)
        else $error("rising edge not counted");
    AST_PRE_CLR_TB: assert property ((wr_tb & !prescaler_assign) |=> pre_value == 8'h00)
        else $error("prescaler not cleared on counter write");
    AST_WDT_CLR: assert property (wdt_clear |=> wdt_cnt_q == '0)
        else $error("watchdog not cleared");
    AST_WDT_STOP: assert property ((!wdt_en & !wdt_clear) |=> $stable(wdt_cnt_q))
        else $error("watchdog ran while disabled");
    AST_OVF_FLAG: assert property (tb_wrap |=> flag_q[tmwd_pkg::IRQ_OVF] && tb_q == 8'h00)
        else $error("overflow flag not set on wrap");
    AST_WDT_RESET: assert property (wdt_timeout |=> wdt_reset_req ##1 !wdt_reset_req)
        else $error("timeout did not pulse reset");
    AST_DIV_PERIOD: assert property ((instr_tick & clk_code_option & !sleep_active)
        |=> !instr_tick [*3])
        else $error("instruction tick too frequent");

    COV_WRAP: cover property (tb_wrap);
    COV_WDT_TIMEOUT: cover property (wdt_timeout & sleep_active);
    COV_EXT_IRQ: cover property (flag_set[tmwd_pkg::IRQ_EXT] ##1 irq_request);
    COV_SLEEP_WAKE: cover property (sleep_active ##1 !sleep_active);

endmodule : tmwd_top

`default_nettype wire

// ### tmwd_top_tb_top.sv
`default_nettype none

module tmwd_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // Short watchdog base period keeps the run small
    localparam int WDP = 16;
    localparam logic [7:0] TC = tmwd_pkg::OFS_TIMER_CONTROL;
    localparam logic [7:0] WC = tmwd_pkg::OFS_WATCHDOG_CONTROL;
    localparam logic [7:0] IM = tmwd_pkg::OFS_INTERRUPT_MASK;
    localparam logic [7:0] TB = tmwd_pkg::OFS_TIMEBASE;
    localparam logic [7:0] FLG = tmwd_pkg::OFS_IRQ_FLAG;
    localparam logic [7:0] CMD = tmwd_pkg::OFS_COMMAND;
    localparam logic [7:0] ST = tmwd_pkg::OFS_STATUS;

    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic clk_code_option, port6_pin0, port6_pin2, port_change_event, irq_entry;
    logic irq_request, wdt_reset_req, sleep_active;
    logic port6_pin0_is_irq, port6_pin2_is_counter, ext_irq_pin_level;
    int error_cnt, num_checks;

    assign hready = hreadyout;

    tmwd_top #(.WDT_PERIOD_CYC(WDP)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .clk_code_option(clk_code_option), .port6_pin0(port6_pin0),
        .port6_pin2(port6_pin2), .port_change_event(port_change_event),
        .irq_entry(irq_entry), .irq_request(irq_request), .wdt_reset_req(wdt_reset_req),
        .sleep_active(sleep_active), .port6_pin0_is_irq(port6_pin0_is_irq),
        .port6_pin2_is_counter(port6_pin2_is_counter), .ext_irq_pin_level(ext_irq_pin_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic cycles(input int n);
        repeat (n) @(posedge hclk);
    endtask : cycles

    // Never assumes a wait-state count
    task automatic rdy;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hready !== 1'b1 && i < 50);
        if (hready !== 1'b1) begin
            chk(32'h0, 32'h1, "bus timeout");
            conclude();
        end
    endtask : rdy

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        rdy();
        rd = hrdata;
    endtask : bus

    // Address phases exactly s cycles apart
    task automatic delta(input int s, output logic [7:0] d);
        logic [7:0] a;
        bus(1'b0, TB, 32'h0);
        a = rd[7:0];
        cycles(s - 3);
        bus(1'b0, TB, 32'h0);
        d = rd[7:0] - a;
    endtask : delta

    // Cycles until the next timeout pulse, or the bound
    task automatic wpulse(input int bound, output int n);
        n = 0;
        do begin
            @(posedge hclk);
            #1;
            n++;
        end while (wdt_reset_req !== 1'b1 && n < bound);
    endtask : wpulse

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        bus(1'b0, TC, 32'h0);
        chk(rd, 32'hBF, "tc reset");
        bus(1'b0, WC, 32'h0);
        chk(rd, 32'h80, "wc reset");
        bus(1'b0, IM, 32'h0);
        chk(rd, 32'hF8, "mask reset");
        bus(1'b0, 8'h3C, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        chk({31'h0, hresp}, 32'h0, "bus response");
        chk({30'h0, port6_pin0_is_irq, port6_pin2_is_counter}, 32'h1, "pin modes");
    endtask : t_reset

    task automatic t_regs;
        logic [7:0] v[2] = '{8'hB5, 8'h4A};
        logic [7:0] w[2] = '{8'h7F, 8'h80};
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, TC, {24'h0, v[i]});
            bus(1'b0, TC, 32'h0);
            chk(rd, {24'h0, v[i]}, "tc rw");
            chk({31'h0, port6_pin2_is_counter}, {31'h0, v[i][5]}, "pin2 mode");
            bus(1'b1, WC, {24'h0, w[i]});
            bus(1'b0, WC, 32'h0);
            chk(rd, {24'h0, w[i]}, "wc rw");
            chk({31'h0, port6_pin0_is_irq}, {31'h0, w[i][6]}, "pin0 mode");
        end
        bus(1'b1, IM, 32'h05);
        bus(1'b0, IM, 32'h0);
        chk(rd, 32'hFD, "mask rw");
        bus(1'b1, IM, 32'h02);
        bus(1'b0, IM, 32'h0);
        chk(rd, 32'hFA, "mask rw");
    endtask : t_regs

    task automatic t_count;
        logic [7:0] d;
        bus(1'b1, WC, 32'h0);
        bus(1'b1, TC, 32'h08);
        delta(32, d);
        chk({24'h0, d}, 32'd16, "tick over 2");
        clk_code_option <= 1'b1;
        cycles(8);
        delta(32, d);
        chk({24'h0, d}, 32'd8, "tick over 4");
        // Option is a fixed code setting; change it back only under reset
        hresetn <= 1'b0;
        clk_code_option <= 1'b0;
        cycles(2);
        hresetn <= 1'b1;
        bus(1'b0, TC, 32'h0);
        chk(rd, 32'hBF, "tc after reset");
        bus(1'b1, WC, 32'h0);
        for (int n = 0; n < 4; n++) begin
            bus(1'b1, TC, n);
            delta(64, d);
            chk({24'h0, d}, 32'd16 >> n, "counter ratio");
        end
        bus(1'b1, TC, 32'h07);
        bus(1'b1, TB, 32'h0);
        cycles(200);
        bus(1'b0, ST, 32'h0);
        chk({31'h0, rd[15:8] >= 8'd95 && rd[15:8] <= 8'd110}, 32'h1, "prescaler run");
        bus(1'b1, TB, 32'h0);
        bus(1'b0, ST, 32'h0);
        chk({31'h0, rd[15:8] < 8'd4}, 32'h1, "prescaler clear");
    endtask : t_count

    task automatic t_ext;
        logic [7:0] a;
        for (int e = 0; e < 2; e++) begin
            bus(1'b1, TC, 32'h28 | (e << 4));
            bus(1'b0, TB, 32'h0);
            a = rd[7:0];
            repeat (10) begin
                port6_pin2 <= ~port6_pin2;
                cycles(2);
            end
            bus(1'b0, TB, 32'h0);
            chk({24'h0, rd[7:0] - a}, 32'd5, "pin edges");
        end
    endtask : t_ext

    task automatic t_irq;
        int i;
        bus(1'b1, IM, 32'h01);
        bus(1'b1, TC, 32'h08);
        bus(1'b1, CMD, 32'h02);
        bus(1'b0, TC, 32'h0);
        chk(rd, 32'h48, "enable instr");
        bus(1'b1, TB, 32'hFE);
        i = 0;
        while (irq_request !== 1'b1 && i < 40) begin
            @(posedge hclk);
            i++;
        end
        chk({31'h0, irq_request}, 32'h1, "overflow request");
        bus(1'b0, FLG, 32'h0);
        chk({31'h0, rd[0]}, 32'h1, "overflow flag");
        bus(1'b1, CMD, 32'h01);
        cycles(2);
        chk({31'h0, irq_request}, 32'h0, "disable instr");
        bus(1'b1, CMD, 32'h04);
        cycles(2);
        chk({31'h0, irq_request}, 32'h1, "return instr");
        irq_entry <= 1'b1;
        cycles(1);
        irq_entry <= 1'b0;
        bus(1'b0, TC, 32'h0);
        chk(rd, 32'h08, "entry masks");
        bus(1'b1, FLG, 32'h07);
        bus(1'b1, IM, 32'h0);
        bus(1'b1, CMD, 32'h02);
        port_change_event <= 1'b1;
        cycles(1);
        port_change_event <= 1'b0;
        cycles(2);
        chk({31'h0, irq_request}, 32'h0, "change masked");
        bus(1'b1, IM, 32'h02);
        cycles(2);
        chk({31'h0, irq_request}, 32'h1, "change enabled");
        bus(1'b1, FLG, 32'h02);
        bus(1'b1, IM, 32'h04);
        port6_pin0 <= 1'b0;
        cycles(3);
        chk({31'h0, irq_request}, 32'h0, "pin path masked");
        chk({31'h0, ext_irq_pin_level}, 32'h0, "pin level");
        port6_pin0 <= 1'b1;
        bus(1'b1, WC, 32'h40);
        port6_pin0 <= 1'b0;
        cycles(3);
        chk({31'h0, irq_request}, 32'h1, "pin interrupt");
        port6_pin0 <= 1'b1;
        bus(1'b1, CMD, 32'h01);
        bus(1'b1, FLG, 32'h07);
    endtask : t_irq

    task automatic t_wdt;
        int n;
        bus(1'b1, TC, 32'h00);
        bus(1'b1, WC, 32'h80);
        wpulse(3000, n);
        wpulse(3000, n);
        chk(n, WDP, "watchdog period");
        bus(1'b1, TC, 32'h0A);
        wpulse(3000, n);
        wpulse(3000, n);
        chk(n, WDP * 4, "watchdog ratio");
        bus(1'b1, TC, 32'h0F);
        bus(1'b1, CMD, 32'h08);
        cycles(100);
        bus(1'b0, ST, 32'h0);
        chk({31'h0, rd[15:8] >= 8'd4}, 32'h1, "wdt prescaler runs");
        bus(1'b1, CMD, 32'h08);
        bus(1'b0, ST, 32'h0);
        chk({31'h0, rd[15:8] <= 8'd1}, 32'h1, "wdt clear");
        bus(1'b1, TC, 32'h00);
        bus(1'b1, WC, 32'h00);
        wpulse(100, n);
        chk(n, 32'd100, "watchdog off");
        bus(1'b1, WC, 32'h80);
        wpulse(40, n);
        chk({31'h0, n <= WDP + 3}, 32'h1, "watchdog on");
        bus(1'b1, CMD, 32'h10);
        bus(1'b0, ST, 32'h0);
        chk({31'h0, rd[0]}, 32'h1, "sleep entered");
        wpulse(40, n);
        chk({31'h0, n < 40}, 32'h1, "timeout in sleep");
        cycles(2);
        chk({31'h0, sleep_active}, 32'h0, "sleep woken");
        bus(1'b1, WC, 32'h00);
    endtask : t_wdt

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    initial begin
        repeat (100000) @(posedge hclk);
        chk(32'h0, 32'h1, "run timeout");
        conclude();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        clk_code_option = 1'b0;
        port6_pin0 = 1'b1;
        port6_pin2 = 1'b0;
        port_change_event = 1'b0;
        irq_entry = 1'b0;
        error_cnt = 0;
        num_checks = 0;
        cycles(5);
        hresetn <= 1'b1;
        t_reset();
        t_regs();
        t_count();
        t_ext();
        t_irq();
        t_wdt();
        conclude();
    end

endmodule : tmwd_top_tb_top

`default_nettype wire
